/* dss_field_master.sv */
`timescale 1ns/10ps
// ****
// Field bus master model
// ****
module dss_field_master (
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic [15:0] data_i,
    output logic             cmd_wr_o = 1'b0,
    output logic [15:0]      cmd_wdata_o = 16'h5a5a
);
    // One strobe per request; idle data bus toggles every cycle
    always @(posedge clk_i)
    begin
        cmd_wr_o    <= req_i;
        cmd_wdata_o <= req_i ? data_i : ~cmd_wdata_o;
    end
endmodule // dss_field_master

/* dss_params.svh */
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH

// ****************************************
// Timing
// ****************************************
`define DSS_CLK_PERIOD_NS      10
`define DSS_WDOG_UNIT_MS       100
// Cycles per watchdog tick of one tenth of a second
`define DSS_WDOG_TICK_CYCLES   ((`DSS_WDOG_UNIT_MS * 1000000) / `DSS_CLK_PERIOD_NS)
`define DSS_WDOG_MAX_TENTHS    10'h258

// ****************************************
// Remote command word bit positions
// ****************************************
`define DSS_CMD_RUN_BIT        0
`define DSS_CMD_INCH_BIT       1
`define DSS_CMD_PERMIT_BIT     2
`define DSS_CMD_RESET_BIT      3

// ****************************************
// Status word bit positions
// ****************************************
`define DSS_ST_READY_BIT       0
`define DSS_ST_START_BIT       1
`define DSS_ST_ENABLE_BIT      2
`define DSS_ST_COIL_BIT        3
`define DSS_ST_RUNNING_BIT     4
`define DSS_ST_REMOTE_BIT      5
`define DSS_ST_TIMEOUT_BIT     6
`define DSS_ST_RESETP_BIT      7
`define DSS_ST_STATE_LSB       8

// ****************************************
// Reset values
// ****************************************
`define DSS_CMD_RESET_VAL      16'h0000
// Pin synchroniser idle levels, stop pins high
`define DSS_PIN_SYNC_RESET     5'h18

`endif

/* dss_pkg.sv */
package dss_pkg;

    // Sequencer state codes, in reported order
    typedef enum logic [3:0] {
        SEQ_INIT_A,
        SEQ_INIT_B,
        SEQ_HOLD,
        SEQ_STANDBY,
        SEQ_PRE_READY,
        SEQ_READY,
        SEQ_AUTOTUNE,
        SEQ_RUN,
        SEQ_ZERO_SPD,
        SEQ_QUENCH,
        SEQ_PROG_STOP,
        SEQ_STOP,
        SEQ_DELAY_STOP,
        SEQ_CUR_DECAY,
        SEQ_COAST_STOP,
        SEQ_ERROR
    } dss_state_type;

endpackage

/* dss_sequencer.sv */
`timescale 1ns/10ps
`include "dss_params.svh"

// Contract
// - Run request is auxiliary run AND run terminal.
// - Inch request is auxiliary inch AND inch input.
// - Enable is auxiliary enable AND permit input.
// - Start flag is run request OR inch request.
// - In remote mode the remote command word replaces the run, inch and permit terminals; the stop pins still act.
// - Remote command word is 16 bits, effective only in remote mode.
// - Watchdog runs only in remote mode, period 0 to 60 seconds.
// - Zero period disables the watchdog.
// - Each command word write restarts the watchdog count.
// - A 16-bit status word reports the important flags.
// - Contactor flag equals the main coil output.
// - Drive enable flag enables or quenches the control loops.
// - System reset pulses one cycle as the drive becomes enabled.
// - Sequencer state reported as code 0 to 15.
// - Ready flag true when an enable can be accepted.
module dss_sequencer #(
    parameter int unsigned TICK_CYCLES = `DSS_WDOG_TICK_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    input  wire logic        run_terminal_i,
    input  wire logic        inch_terminal_i,
    input  wire logic        permit_terminal_i,
    input  wire logic        program_stop_n_i,
    input  wire logic        coast_stop_n_i,
    input  wire logic        aux_run_i,
    input  wire logic        aux_inch_i,
    input  wire logic        aux_permit_i,
    input  wire logic        remote_control_select_i,
    input  wire logic [9:0]  link_watchdog_period_i,
    input  wire logic        cmd_wr_i,
    input  wire logic [15:0] cmd_wdata_i,
    input  wire logic        at_zero_speed_i,
    output logic [15:0]      remote_command_word_o,
    output logic [15:0]      sequencer_status_word_o,
    output logic [3:0]       sequencer_state_code_o,
    output logic             main_coil_o,
    output logic             main_coil_energised_o,
    output logic             drive_enable_o,
    output logic             drive_start_o,
    output logic             motor_running_flag_o,
    output logic             ready_o,
    output logic             system_reset_o,
    output logic             link_timeout_o
);

    // ****************************************
    // Terminal synchronisers
    // ****************************************
    logic [4:0] pin_s1_r;
    logic [4:0] pin_s2_r;

    // Two flops on every pin input
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pin_s1_r <= `DSS_PIN_SYNC_RESET;
            pin_s2_r <= `DSS_PIN_SYNC_RESET;
        end
        else if (ce_i)
        begin
            pin_s1_r <= {coast_stop_n_i, program_stop_n_i, permit_terminal_i,
                         inch_terminal_i, run_terminal_i};
            pin_s2_r <= pin_s1_r;
        end
    end

    logic run_pin;
    logic inch_pin;
    logic permit_pin;
    logic prog_stop;
    logic coast_stop;
    assign run_pin    = pin_s2_r[0];
    assign inch_pin   = pin_s2_r[1];
    assign permit_pin = pin_s2_r[2];
    assign prog_stop  = !pin_s2_r[3];
    assign coast_stop = !pin_s2_r[4];

    // ****************************************
    // Remote command word
    // ****************************************
    logic [15:0] cmd_r;

    // Field bus master writes the command word
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            cmd_r <= `DSS_CMD_RESET_VAL;
        else if (ce_i && cmd_wr_i)
            cmd_r <= cmd_wdata_i;
    end
    assign remote_command_word_o = cmd_r;

    // ****************************************
    // Request selection
    // ****************************************
    logic run_req;
    logic inch_req;
    logic permit_req;
    logic fault_reset;
    logic remote;

    assign remote = remote_control_select_i;

    // Local AND terms, or remote word only in remote mode
    always_comb
    begin
        if (remote)
        begin
            run_req     = cmd_r[`DSS_CMD_RUN_BIT];
            inch_req    = cmd_r[`DSS_CMD_INCH_BIT];
            permit_req  = cmd_r[`DSS_CMD_PERMIT_BIT];
            fault_reset = cmd_r[`DSS_CMD_RESET_BIT];
        end
        else
        begin
            run_req     = aux_run_i && run_pin;
            inch_req    = aux_inch_i && inch_pin;
            permit_req  = aux_permit_i && permit_pin;
            fault_reset = !run_pin;
        end
    end

    // ****************************************
    // Communications watchdog
    // ****************************************
    logic wdog_expired;

    dss_watchdog #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_wdog (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .active_i  (remote),
        .period_i  (link_watchdog_period_i),
        .kick_i    (cmd_wr_i),
        .expired_o (wdog_expired)
    );

    logic timeout_r;

    // Sticky fault until a write while the watchdog is not expired, or leaving remote mode
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            timeout_r <= 1'b0;
        else if (ce_i)
        begin
            if (wdog_expired)
                timeout_r <= 1'b1;
            else if (cmd_wr_i || !remote)
                timeout_r <= 1'b0;
        end
    end
    assign link_timeout_o = timeout_r;

    // ****************************************
    // Sequencer state machine
    // ****************************************
    dss_pkg::dss_state_type state_r;
    dss_pkg::dss_state_type state_nxt;
    logic start_req;
    logic stop_now;

    assign start_req = run_req || inch_req;
    assign stop_now  = coast_stop || timeout_r;

    // Next state of the start/stop sequence
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            dss_pkg::SEQ_INIT_A:     state_nxt = dss_pkg::SEQ_INIT_B;
            dss_pkg::SEQ_INIT_B:     state_nxt = dss_pkg::SEQ_STANDBY;
            dss_pkg::SEQ_HOLD:
                if (!start_req)
                    state_nxt = dss_pkg::SEQ_STANDBY;
            dss_pkg::SEQ_STANDBY:
                if (!stop_now && !prog_stop)
                    state_nxt = start_req ? dss_pkg::SEQ_HOLD : dss_pkg::SEQ_PRE_READY;
            dss_pkg::SEQ_PRE_READY:
                if (stop_now || prog_stop)
                    state_nxt = dss_pkg::SEQ_STANDBY;
                else if (start_req)
                    state_nxt = dss_pkg::SEQ_READY;
            dss_pkg::SEQ_READY:
                if (stop_now)
                    state_nxt = dss_pkg::SEQ_COAST_STOP;
                else if (!start_req)
                    state_nxt = dss_pkg::SEQ_PRE_READY;
                else if (permit_req)
                    state_nxt = dss_pkg::SEQ_RUN;
            dss_pkg::SEQ_AUTOTUNE:   state_nxt = dss_pkg::SEQ_READY;
            dss_pkg::SEQ_RUN:
                if (stop_now)
                    state_nxt = dss_pkg::SEQ_COAST_STOP;
                else if (prog_stop)
                    state_nxt = dss_pkg::SEQ_PROG_STOP;
                else if (!permit_req)
                    state_nxt = dss_pkg::SEQ_QUENCH;
                else if (!start_req)
                    state_nxt = dss_pkg::SEQ_STOP;
            dss_pkg::SEQ_QUENCH:
                state_nxt = dss_pkg::SEQ_CUR_DECAY;
            dss_pkg::SEQ_PROG_STOP, dss_pkg::SEQ_STOP:
                if (stop_now)
                    state_nxt = dss_pkg::SEQ_COAST_STOP;
                else if (at_zero_speed_i)
                    state_nxt = dss_pkg::SEQ_ZERO_SPD;
            dss_pkg::SEQ_ZERO_SPD:   state_nxt = dss_pkg::SEQ_DELAY_STOP;
            dss_pkg::SEQ_DELAY_STOP: state_nxt = dss_pkg::SEQ_CUR_DECAY;
            dss_pkg::SEQ_CUR_DECAY:
                state_nxt = timeout_r ? dss_pkg::SEQ_ERROR : dss_pkg::SEQ_STANDBY;
            dss_pkg::SEQ_COAST_STOP:
                state_nxt = timeout_r ? dss_pkg::SEQ_ERROR : dss_pkg::SEQ_CUR_DECAY;
            dss_pkg::SEQ_ERROR:
                if (!timeout_r && fault_reset)
                    state_nxt = dss_pkg::SEQ_STANDBY;
        endcase
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            state_r <= dss_pkg::SEQ_INIT_A;
        else if (ce_i)
            state_r <= state_nxt;
    end

    // ****************************************
    // Output flags
    // ****************************************
    logic coil_r;
    logic enable_r;
    logic start_r;
    logic ready_r;
    logic running_r;
    logic sys_reset_r;
    logic coil_nxt;
    logic enable_nxt;

    // Coil in ready, run, both stops, zero speed and delay stop; loops enabled in run and both stops
    always_comb
    begin
        coil_nxt   = (state_nxt == dss_pkg::SEQ_READY)
                  || (state_nxt == dss_pkg::SEQ_RUN)
                  || (state_nxt == dss_pkg::SEQ_STOP)
                  || (state_nxt == dss_pkg::SEQ_PROG_STOP)
                  || (state_nxt == dss_pkg::SEQ_ZERO_SPD)
                  || (state_nxt == dss_pkg::SEQ_DELAY_STOP);
        enable_nxt = (state_nxt == dss_pkg::SEQ_RUN)
                  || (state_nxt == dss_pkg::SEQ_STOP)
                  || (state_nxt == dss_pkg::SEQ_PROG_STOP);
    end

    // Registered flags and enable-edge reset pulse
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            coil_r      <= 1'b0;
            enable_r    <= 1'b0;
            start_r     <= 1'b0;
            ready_r     <= 1'b0;
            running_r   <= 1'b0;
            sys_reset_r <= 1'b0;
        end
        else if (ce_i)
        begin
            coil_r      <= coil_nxt;
            enable_r    <= enable_nxt;
            start_r     <= start_req;
            ready_r     <= (state_nxt == dss_pkg::SEQ_READY);
            running_r   <= (state_nxt == dss_pkg::SEQ_RUN);
            sys_reset_r <= enable_nxt && !enable_r;
        end
    end

    assign main_coil_o            = coil_r;
    assign main_coil_energised_o  = coil_r;
    assign drive_enable_o         = enable_r;
    assign drive_start_o          = start_r;
    assign ready_o                = ready_r;
    assign motor_running_flag_o   = running_r;
    assign system_reset_o         = sys_reset_r;
    assign sequencer_state_code_o = state_r;

    // ****************************************
    // Status word
    // ****************************************
    // Flags packed for the field bus
    always_comb
    begin
        sequencer_status_word_o = 16'h0000;
        sequencer_status_word_o[`DSS_ST_READY_BIT]   = ready_r;
        sequencer_status_word_o[`DSS_ST_START_BIT]   = start_r;
        sequencer_status_word_o[`DSS_ST_ENABLE_BIT]  = enable_r;
        sequencer_status_word_o[`DSS_ST_COIL_BIT]    = coil_r;
        sequencer_status_word_o[`DSS_ST_RUNNING_BIT] = running_r;
        sequencer_status_word_o[`DSS_ST_REMOTE_BIT]  = remote;
        sequencer_status_word_o[`DSS_ST_TIMEOUT_BIT] = timeout_r;
        sequencer_status_word_o[`DSS_ST_RESETP_BIT]  = sys_reset_r;
        sequencer_status_word_o[`DSS_ST_STATE_LSB +: 4] = state_r;
    end

endmodule // dss_sequencer

/* dss_sequencer_chk.sv */
`timescale 1ns/10ps
// ****
// Sequencer checker
// ****
module dss_sequencer_chk #(
    parameter int unsigned TICK_CYCLES = 4
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    input  wire logic        remote_control_select_i,
    input  wire logic [9:0]  link_watchdog_period_i,
    input  wire logic        cmd_wr_i,
    input  wire logic [15:0] cmd_wdata_i,
    input  wire logic [15:0] remote_command_word_o,
    input  wire logic [15:0] sequencer_status_word_o,
    input  wire logic [3:0]  sequencer_state_code_o,
    input  wire logic        main_coil_o,
    input  wire logic        main_coil_energised_o,
    input  wire logic        drive_enable_o,
    input  wire logic        drive_start_o,
    input  wire logic        motor_running_flag_o,
    input  wire logic        ready_o,
    input  wire logic        system_reset_o,
    input  wire logic        link_timeout_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Accepted command write and watchdog trip
    sequence s_wr; ce_i && cmd_wr_i; endsequence
    sequence s_trip; $rose(link_timeout_o); endsequence
    // One-cycle reset pulse
    sequence s_pulse; system_reset_o ##1 !system_reset_o; endsequence

    AST_WORD: assert property (
        s_wr |=> remote_command_word_o == $past(cmd_wdata_i)) else $error("word readback wrong");
    AST_COIL: assert property (
        main_coil_energised_o == main_coil_o) else $error("coil flag differs");
    AST_PULSE: assert property (
        $rose(drive_enable_o) |-> s_pulse) else $error("pulse wrong");
    AST_LOOPS: assert property (
        drive_enable_o == (sequencer_state_code_o inside {4'h7, 4'ha, 4'hb}))
        else $error("loop enable wrong");
    AST_CAUSE: assert property (
        system_reset_o |-> $rose(drive_enable_o)) else $error("stray reset pulse");
    AST_READY: assert property (
        ready_o == (sequencer_state_code_o == 4'h5)) else $error("ready flag wrong");
    AST_STAT: assert property (
        sequencer_status_word_o == {4'h0, sequencer_state_code_o, system_reset_o,
        link_timeout_o, remote_control_select_i, motor_running_flag_o, main_coil_o,
        drive_enable_o, drive_start_o, ready_o}) else $error("status word wrong");
    AST_ARMED: assert property (
        s_trip |-> $past(remote_control_select_i) && $past(link_watchdog_period_i) != 10'h000)
        else $error("trip while disarmed");
    AST_KICK: assert property (
        s_trip |-> !$past(cmd_wr_i) && !$past(cmd_wr_i, 2) && !$past(cmd_wr_i, 3))
        else $error("trip right after write");
    AST_STOP: assert property (
        s_trip |-> ##[0:4] (sequencer_state_code_o inside {4'he, 4'hf} && !drive_enable_o))
        else $error("no stop after trip");
endmodule // dss_sequencer_chk

bind dss_sequencer dss_sequencer_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .remote_control_select_i(remote_control_select_i),
    .link_watchdog_period_i(link_watchdog_period_i),
    .cmd_wr_i(cmd_wr_i), .cmd_wdata_i(cmd_wdata_i),
    .remote_command_word_o(remote_command_word_o),
    .sequencer_status_word_o(sequencer_status_word_o),
    .sequencer_state_code_o(sequencer_state_code_o),
    .main_coil_o(main_coil_o), .main_coil_energised_o(main_coil_energised_o),
    .drive_enable_o(drive_enable_o), .drive_start_o(drive_start_o),
    .motor_running_flag_o(motor_running_flag_o), .ready_o(ready_o),
    .system_reset_o(system_reset_o), .link_timeout_o(link_timeout_o));

/* dss_sequencer_tb.sv */
`timescale 1ns/10ps
`define CHECK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
// ****
// Sequencer testbench
// ****
module dss_sequencer_tb;
    logic        clk_i = 0, sys_rst_i = 1, run_t = 0, inch_t = 0, permit_t = 0;
    logic        aux_run = 1, aux_inch = 1, aux_permit = 1, remote = 0, req = 0;
    logic        pstop_n = 1, cstop_n = 1, at_zero = 0, ce = 1;
    logic [9:0]  period = 10'h000;
    logic [15:0] wdata = 16'h0000;
    logic        cmd_wr, coil, coil_e, en, start, running, ready, sysrst, tmo;
    logic [15:0] cmd_wdata, word, status;
    logic [3:0]  state;
    int          fail_count = 0;
    int          checked = 0;

    // Clock of 10 ns
    initial forever #5 clk_i = ~clk_i;

    dss_field_master u_master (.clk_i(clk_i), .req_i(req), .data_i(wdata),
        .cmd_wr_o(cmd_wr), .cmd_wdata_o(cmd_wdata));

    dss_sequencer #(.TICK_CYCLES(4)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
        .run_terminal_i(run_t), .inch_terminal_i(inch_t), .permit_terminal_i(permit_t),
        .program_stop_n_i(pstop_n), .coast_stop_n_i(cstop_n), .aux_run_i(aux_run),
        .aux_inch_i(aux_inch), .aux_permit_i(aux_permit), .remote_control_select_i(remote),
        .link_watchdog_period_i(period), .cmd_wr_i(cmd_wr), .cmd_wdata_i(cmd_wdata),
        .at_zero_speed_i(at_zero), .remote_command_word_o(word),
        .sequencer_status_word_o(status), .sequencer_state_code_o(state),
        .main_coil_o(coil), .main_coil_energised_o(coil_e), .drive_enable_o(en),
        .drive_start_o(start), .motor_running_flag_o(running), .ready_o(ready),
        .system_reset_o(sysrst), .link_timeout_o(tmo));

    // Wait n edges, then settle
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Bounded wait for a state code
    task automatic wait_state(input logic [3:0] code);
        int n;
        n = 0;
        while (state !== code && n < 80)
        begin
            tick(1);
            n++;
        end
        `CHECK(state, code)
    endtask

    // One command word write through the master
    task automatic bus_write(input logic [15:0] d);
        @(posedge clk_i);
        req   <= 1'b1;
        wdata <= d;
        @(posedge clk_i);
        req   <= 1'b0;
    endtask

    // Verdict and end of run
    task automatic conclude();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        #50000;
        fail_count++;
        conclude();
    end

    // Main sequence
    initial
    begin
        tick(5);
        sys_rst_i <= 1'b0;
        wait_state(4'h4);
        `CHECK(status, 16'h0400)
        aux_run <= 1'b0;
        run_t   <= 1'b1;
        tick(8);
        `CHECK({state, start}, {4'h4, 1'b0})
        inch_t <= 1'b1;
        wait_state(4'h5);
        `CHECK(status, 16'h050b)
        aux_run    <= 1'b1;
        inch_t     <= 1'b0;
        permit_t   <= 1'b1;
        aux_permit <= 1'b0;
        tick(8);
        `CHECK({state, en}, {4'h5, 1'b0})
        aux_permit <= 1'b1;
        wait_state(4'h7);
        `CHECK(status, 16'h079e)
        tick(1);
        `CHECK(status, 16'h071e)
        permit_t <= 1'b0;
        wait_state(4'h9);
        `CHECK(en, 1'b0)
        run_t <= 1'b0;
        wait_state(4'h4);
        // Remote mode, local permit off
        remote <= 1'b1;
        bus_write(16'h0007);
        tick(2);
        `CHECK(word, 16'h0007)
        wait_state(4'h7);
        `CHECK(status, 16'h07be)
        tick(40);
        `CHECK(tmo, 1'b0)
        period <= 10'h001;
        repeat (6)
        begin
            bus_write(16'h0007);
            tick(1);
        end
        `CHECK(tmo, 1'b0)
        repeat (20) if (tmo !== 1'b1) tick(1);
        `CHECK(tmo, 1'b1)
        wait_state(4'hf);
        period <= 10'h000;
        bus_write(16'h0008);
        tick(2);
        `CHECK(tmo, 1'b0)
        wait_state(4'h4);
        // Stop paths, hold state and clock-enable freeze
        bus_write(16'h0005);
        wait_state(4'h7);
        pstop_n <= 1'b0;
        wait_state(4'ha);
        `CHECK({en, coil}, 2'b11)
        at_zero <= 1'b1;
        wait_state(4'h8);
        `CHECK({en, coil}, 2'b01)
        wait_state(4'h3);
        pstop_n <= 1'b1;
        at_zero <= 1'b0;
        wait_state(4'h2);
        bus_write(16'h0004);
        wait_state(4'h4);
        bus_write(16'h0005);
        wait_state(4'h7);
        bus_write(16'h0004);
        wait_state(4'hb);
        `CHECK({en, coil}, 2'b11)
        at_zero <= 1'b1;
        wait_state(4'h4);
        ce <= 1'b0;
        bus_write(16'h0005);
        tick(4);
        `CHECK({state, word}, {4'h4, 16'h0004})
        ce <= 1'b1;
        tick(3);
        `CHECK({state, word}, {4'h4, 16'h0004})
        conclude();
    end
endmodule // dss_sequencer_tb

/* dss_watchdog.sv */
`timescale 1ns/10ps
`include "dss_params.svh"

module dss_watchdog #(
    parameter int unsigned TICK_CYCLES = `DSS_WDOG_TICK_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       ce_i,
    input  wire logic       active_i,
    input  wire logic [9:0] period_i,
    input  wire logic       kick_i,
    output logic            expired_o
);

    logic [31:0] tick_cnt_r;
    logic [9:0]  tenth_cnt_r;
    logic        armed;
    logic [9:0]  limit;

    // Period clamped to sixty seconds
    assign limit = (period_i > `DSS_WDOG_MAX_TENTHS) ? `DSS_WDOG_MAX_TENTHS : period_i;

    // Watchdog runs only in remote mode with non-zero period
    assign armed = active_i && (period_i != 10'h000);

    // ****************************************
    // Counters
    // ****************************************
    // Restart on every write, else count tenths of a second
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            tick_cnt_r  <= 32'h0;
            tenth_cnt_r <= 10'h000;
            expired_o   <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!armed || kick_i)
            begin
                tick_cnt_r  <= 32'h0;
                tenth_cnt_r <= 10'h000;
                expired_o   <= 1'b0;
            end
            else if (tenth_cnt_r >= limit)
                expired_o <= 1'b1;
            else if (tick_cnt_r == TICK_CYCLES - 1)
            begin
                tick_cnt_r  <= 32'h0;
                tenth_cnt_r <= tenth_cnt_r + 10'h001;
            end
            else
                tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

endmodule // dss_watchdog
